// ---- include/igo_regs.vh ----
// constants for the initialization and global override pin block
`ifndef IGO_REGS_VH
`define IGO_REGS_VH
// init sequencer states
`define IGO_ST_IDLE 3'h0
`define IGO_ST_LOAD 3'h1
`define IGO_ST_INIT 3'h2
`define IGO_ST_USER 3'h3
`define IGO_ST_WIDTH 3
// cycles of the start-up clock that initialization takes
`define IGO_INIT_CYCLES 8'h10
`define IGO_INIT_CNT_WIDTH 8
// synchroniser reset: restart asserted, start-up clock low, override pins idle high
`define IGO_SYNC_RST 4'h3
// optional pin synchroniser reset, all pins low
`define IGO_PIN_RST 4'h0
`endif

// ---- src/igo_init_override.v ----
// device-side init sequencing, init-done pin and global override pins
`timescale 1ns/100ps
`default_nettype none
`include "igo_regs.vh"

module igo_init_override #(
  parameter NUM_IO = 8,
  parameter [`IGO_INIT_CNT_WIDTH-1:0] INIT_CYCLES = `IGO_INIT_CYCLES
) (
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_config_restart_n,
  input wire i_opt_user_startup_clock,
  input wire i_opt_init_done,
  input wire i_opt_global_output_enable,
  input wire i_opt_global_register_clear,
  input wire i_frame_end,
  input wire i_config_done,
  input wire i_user_startup_clock,
  input wire i_global_output_enable,
  input wire i_global_register_clear_n,
  input wire [NUM_IO-1:0] i_user_oe,
  input wire [NUM_IO-1:0] i_user_out,
  input wire [3:0] i_pin_in,
  output wire [NUM_IO-1:0] o_io_oe,
  output wire [NUM_IO-1:0] o_io_out,
  output wire o_init_done_out,
  output wire o_init_done_oe,
  output wire [3:0] o_pin_oe,
  output wire [3:0] o_pin_out,
  output wire [3:0] o_pin_user_in,
  output wire o_reg_clear,
  output reg o_user_mode
);

  // ****************************************
  // input synchronisers
  // ****************************************
  // bit order: restart, start-up clock, output enable, register clear
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg uclk_prev_q;

  // pins come from off-chip, so two flops before any use; reset values
  // match the idle pin levels, so no false start-up clock edge follows reset
  always @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1_q <= `IGO_SYNC_RST;
      sync2_q <= `IGO_SYNC_RST;
      uclk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {i_config_restart_n, i_user_startup_clock, i_global_output_enable,
        i_global_register_clear_n};
      sync2_q <= sync1_q;
      uclk_prev_q <= sync2_q[2];
    end
  end

  // restart reads as asserted until the pin has been seen high twice
  wire restart_n_s = sync2_q[3];
  wire uclk_s = sync2_q[2];
  wire goe_s = sync2_q[1];
  wire gclr_n_s = sync2_q[0];

  // limitation: start-up clock highs and lows must each last a reference
  // period, or edges are lost in the synchroniser
  // start-up clock edge, or internal tick when the option is off
  wire init_tick = i_opt_user_startup_clock ? (uclk_s & ~uclk_prev_q) : 1'b1;

  // ****************************************
  // init sequencer
  // ****************************************
  reg [`IGO_ST_WIDTH-1:0] state_q;
  reg [`IGO_ST_WIDTH-1:0] state_d;
  reg [`IGO_INIT_CNT_WIDTH-1:0] cnt_q;
  reg [`IGO_INIT_CNT_WIDTH-1:0] cnt_d;
  reg en_loaded_q;
  reg en_loaded_d;

  // one step per reference clock; restart wins over every state
  // next state; restart low sends the state back to idle
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    en_loaded_d = en_loaded_q;
    case (state_q)
      `IGO_ST_IDLE:
      begin
        // a fresh configuration forgets the old enable bit
        en_loaded_d = 1'b0;
        if (restart_n_s)
          state_d = `IGO_ST_LOAD;
      end
      `IGO_ST_LOAD:
      begin
        if (i_frame_end)
          en_loaded_d = i_opt_init_done;
        if (i_config_done)
        begin
          state_d = `IGO_ST_INIT;
          cnt_d = {`IGO_INIT_CNT_WIDTH{1'b0}};
        end
      end
      `IGO_ST_INIT:
      begin
        // fixed edge count keeps devices on a shared clock in step
        if (init_tick)
        begin
          if (cnt_q == INIT_CYCLES - 1'b1)
            state_d = `IGO_ST_USER;
          else
            cnt_d = cnt_q + 1'b1;
        end
      end
      `IGO_ST_USER:
        state_d = `IGO_ST_USER;
      default:
        state_d = `IGO_ST_IDLE;
    endcase
    if (!restart_n_s)
      state_d = `IGO_ST_IDLE;
  end

  // user mode and pin release come from one state, so they move on one edge
  // sequencer registers
  always @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= `IGO_ST_IDLE;
      cnt_q <= {`IGO_INIT_CNT_WIDTH{1'b0}};
      en_loaded_q <= 1'b0;
      o_user_mode <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      en_loaded_q <= en_loaded_d;
      o_user_mode <= (state_d == `IGO_ST_USER);
    end
  end

  // ****************************************
  // init-done open drain
  // ****************************************
  // only ever pulls low; high comes from the board pull-up
  reg init_low_q;
  always @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      init_low_q <= 1'b0;
    else
      init_low_q <= en_loaded_d && (state_d == `IGO_ST_LOAD || state_d == `IGO_ST_INIT);
  end
  assign o_init_done_out = 1'b0;
  assign o_init_done_oe = init_low_q;

  // ****************************************
  // global overrides
  // ****************************************
  // overrides only count once the option is set, else pin is plain I/O
  // held off until user mode, so configuration itself is never disturbed;
  // oe path stays combinational after the synchroniser for a fast tri-state
  wire goe_active = i_opt_global_output_enable & o_user_mode;
  wire gclr_active = i_opt_global_register_clear & o_user_mode;
  assign o_io_oe = (goe_active && !goe_s) ? {NUM_IO{1'b0}} : i_user_oe;
  assign o_io_out = i_user_out;
  assign o_reg_clear = gclr_active & ~gclr_n_s;

  // ****************************************
  // optional pins as user I/O
  // ****************************************
  // order: start-up clock, init-done, output enable, register clear
  wire [3:0] opt_on = {i_opt_user_startup_clock, i_opt_init_done,
    i_opt_global_output_enable, i_opt_global_register_clear};
  reg [3:0] pin_sync1_q;
  reg [3:0] pin_sync2_q;
  reg [3:0] pin_user_q;

  // raw pin levels are asynchronous too; the last flop keeps the data registered
  always @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_sync1_q <= `IGO_PIN_RST;
      pin_sync2_q <= `IGO_PIN_RST;
      pin_user_q <= `IGO_PIN_RST;
    end
    else
    begin
      pin_sync1_q <= i_pin_in;
      pin_sync2_q <= pin_sync1_q;
      // a pin taken by its dedicated function reads as zero
      pin_user_q <= pin_sync2_q & ~opt_on;
    end
  end

  // tri-stated user I/O until user logic exists
  assign o_pin_oe = 4'h0;
  assign o_pin_out = 4'h0;
  assign o_pin_user_in = pin_user_q;

endmodule // igo_init_override
`default_nettype wire

// ---- tb/igo_board.sv ----
// board pull-up and edge monitor on the init done pin
`timescale 1ns/100ps
`default_nettype none
module igo_board (
  input wire logic i_ref_clk,
  input wire logic i_oe,
  input wire logic i_out,
  output logic o_pad,
  output logic [3:0] o_rises
);
  logic pad_q = 1'h1;
  logic [3:0] rise_q = 4'h0;
  // open drain: a released pin floats up on the pull-up
  assign o_pad = i_oe ? i_out : 1'h1;
  assign o_rises = rise_q;
  // count rising edges, since a high level alone also means never configured
  always @(posedge i_ref_clk)
  begin
    pad_q <= o_pad;
    rise_q <= rise_q + {3'h0, o_pad & ~pad_q};
  end
endmodule // igo_board
`default_nettype wire

// ---- tb/igo_init_override_properties.sv ----
// assertions on the init and override pin block
`timescale 1ns/100ps
`default_nettype none
module igo_props #(parameter NUM_IO = 8) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_config_restart_n,
  input wire logic i_opt_global_output_enable,
  input wire logic i_opt_global_register_clear,
  input wire logic i_frame_end,
  input wire logic i_global_output_enable,
  input wire logic i_global_register_clear_n,
  input wire logic [NUM_IO-1:0] i_user_oe,
  input wire logic [NUM_IO-1:0] o_io_oe,
  input wire logic o_init_done_out,
  input wire logic o_init_done_oe,
  input wire logic o_reg_clear,
  input wire logic o_user_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // pins pass two sync flops, so three samples settle them
  sequence oe_low;
    i_opt_global_output_enable && o_user_mode && !i_global_output_enable;
  endsequence
  sequence clr_low;
    i_opt_global_register_clear && o_user_mode && !i_global_register_clear_n;
  endsequence
  a_frame_drive: assert property ($rose(o_init_done_oe) |-> $past(i_frame_end))
    else $error("drive without frame");
  a_open_drain: assert property (o_init_done_oe |-> !o_init_done_out)
    else $error("pin driven high");
  a_user_free: assert property (o_user_mode |-> !o_init_done_oe)
    else $error("pin held in user mode");
  a_restart_idle: assert property (!i_config_restart_n [*5] |->
    !o_user_mode && !o_init_done_oe) else $error("busy in restart");
  a_oe_forced: assert property (oe_low [*3] |-> o_io_oe == '0)
    else $error("io enabled in override");
  a_oe_follows: assert property (i_global_output_enable [*3] |-> o_io_oe == i_user_oe)
    else $error("io enable ignored");
  a_clr_forced: assert property (clr_low [*3] |-> o_reg_clear)
    else $error("clear not forced");
  a_clr_free: assert property (i_global_register_clear_n [*3] |-> !o_reg_clear)
    else $error("clear with pin high");
  a_oe_opt_off: assert property (!i_opt_global_output_enable |-> o_io_oe == i_user_oe)
    else $error("io enable forced with option off");
  a_clr_opt_off: assert property (!i_opt_global_register_clear |-> !o_reg_clear)
    else $error("clear with option off");
endmodule // igo_props
bind igo_init_override igo_props #(.NUM_IO(NUM_IO)) igo_props_inst (.*);
`default_nettype wire

// ---- tb/tb_igo_init_override.sv ----
// bench for the init and override pin block
`timescale 1ns/100ps
`default_nettype none
module tb_igo_init_override;
  logic i_ref_clk = 1'h0, i_reset_n = 1'h0, i_config_restart_n = 1'h0, i_frame_end = 1'h0;
  logic i_opt_user_startup_clock = 1'h0, i_config_done = 1'h0, i_user_startup_clock = 1'h0;
  logic i_opt_init_done = 1'h1, i_opt_global_output_enable = 1'h1, i_global_output_enable = 1'h1;
  logic i_opt_global_register_clear = 1'h1, i_global_register_clear_n = 1'h1;
  logic [7:0] i_user_oe = 8'h5a, i_user_out = 8'h3c, o_io_oe, o_io_out;
  logic [3:0] i_pin_in = 4'h0, rises, o_pin_oe, o_pin_out, o_pin_user_in;
  logic o_init_done_out, o_init_done_oe, o_reg_clear, o_user_mode, pad;
  int n_errors = 0, checks = 0;
  // 10 MHz; init count cut to 2 so the run stays short
  always #50 i_ref_clk = ~i_ref_clk;
  igo_init_override #(.INIT_CYCLES(8'h02)) igo_init_override_inst (.*);
  igo_board igo_board_inst (.i_ref_clk, .i_oe(o_init_done_oe), .i_out(o_init_done_out),
    .o_pad(pad), .o_rises(rises));
  task automatic chk(input logic [11:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // restart, first frame, data done, then init with or without start-up clock edges
  task automatic t_boot(input logic su, od, input logic [3:0] n_rise);
    i_config_restart_n <= 1'h0;
    go(6);
    chk({o_user_mode, pad}, 2'h1);
    i_opt_user_startup_clock <= su;
    i_opt_init_done <= od;
    i_config_restart_n <= 1'h1;
    go(4);
    i_frame_end <= 1'h1;
    go(1);
    i_frame_end <= 1'h0;
    i_config_done <= 1'h1;
    go(1);
    i_config_done <= 1'h0;
    go(20);
    chk({o_user_mode, pad}, {~su, ~su | ~od});
    repeat (40) @(posedge i_ref_clk) i_user_startup_clock <= ~i_user_startup_clock;
    @(negedge i_ref_clk);
    chk({o_user_mode, pad, rises}, {2'h3, n_rise});
    $display("boot test done");
  endtask
  // both overrides low, then high again, in user mode
  task automatic t_override;
    for (int v = 0; v < 2; v++)
    begin
      go(1);
      i_global_output_enable <= v[0];
      i_global_register_clear_n <= v[0];
      go(4);
      chk({o_reg_clear, o_io_oe}, v ? 9'h05a : 9'h100);
    end
    $display("override test done");
  endtask
  // options off: override pins ignored, their optional pins read back as user I/O
  task automatic t_options;
    go(1);
    i_opt_global_output_enable <= 1'h0;
    i_opt_global_register_clear <= 1'h0;
    i_global_output_enable <= 1'h0;
    i_global_register_clear_n <= 1'h0;
    i_pin_in <= 4'hf;
    go(4);
    chk({o_reg_clear, o_io_oe}, 12'h05a);
    chk({o_io_out, o_pin_user_in}, 12'h3c3);
    chk({o_pin_oe, o_pin_out}, 12'h000);
    i_opt_global_output_enable <= 1'h1;
    i_opt_global_register_clear <= 1'h1;
    i_global_output_enable <= 1'h1;
    i_global_register_clear_n <= 1'h1;
    $display("options test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    go(3);
    i_reset_n <= 1'h1;
    t_boot(1'h0, 1'h1, 4'h1);
    t_override;
    t_boot(1'h1, 1'h1, 4'h2);
    t_options;
    t_boot(1'h1, 1'h0, 4'h2);
    wrap_up;
  end
  // watchdog: the tests need about 250 cycles
  initial
  begin
    #100000;
    n_errors++;
    wrap_up;
  end
endmodule // tb_igo_init_override
`default_nettype wire
